// >>> ddrsb_pkg.sv
// Purpose: shared constants and types of the burst-of-two data port
// Assumes: one core clock; each core clock cycle stands for one input clock phase
// Notes: phase 0 is the rising edge of the true input clock, phase 1 that of its complement
package ddrsb_pkg;
    // geometry of the widest configuration
    localparam int DATA_W = 36;
    localparam int ADDR_W = 19;
    localparam int BYTE_W = 9;
    localparam int FIFO_DEPTH = 4;
    // burst of two words, one word per clock phase
    localparam logic [1:0] BURST_LEN = 2'h2;
    localparam logic [1:0] BURST_NONE = 2'h0;
    // clock phase and direction codes and reset values
    localparam logic PHASE_K = 1'h0;
    localparam logic PHASE_RST = 1'h0;
    localparam logic DIR_READ = 1'h1;
    localparam logic OE_N_RST = 1'h1;

    // write burst sequencing
    typedef enum logic [1:0] {
        DDRSB_WR_IDLE = 2'b00,
        DDRSB_WR_W0 = 2'b01,
        DDRSB_WR_W1 = 2'b10
    } ddrsb_wr_state_t;
endpackage

// >>> ddrsb_stream_if.sv
// Purpose: valid/ready word stream between the port and its read buffer
// Assumes: a single clock domain
// Notes: a word moves on a cycle where valid and ready are both high
`timescale 1ns/1ps
interface ddrsb_stream_if #(
    parameter int W = ddrsb_pkg::DATA_W
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> ddrsb_fifo.sv
// Purpose: small first-in first-out buffer for read words
// Assumes: depth is a power of two
// Notes: ready drops when full so the filling side stalls; valid drops when empty
`timescale 1ns/1ps
module ddrsb_fifo #(
    parameter int W = ddrsb_pkg::DATA_W,
    parameter int DEPTH = ddrsb_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst,
    ddrsb_stream_if.snk in_s,
    ddrsb_stream_if.src out_s
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    // honest full and empty from the fill count
    assign in_s.ready = (count_r != (PW+1)'(DEPTH));
    assign out_s.valid = (count_r != '0);
    assign out_s.data = store[rd_ptr_r];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // storage array
    always_ff @(posedge core_clk) begin
        if (push) begin
            store[wr_ptr_r] <= in_s.data;
        end
    end

    // pointers and count
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + PW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + PW'(1);
            end
            count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// >>> ddrsb_port.sv
// Purpose: burst-of-two double data rate SRAM data and load port with its storage
// Assumes: core_clk cycles alternate between the true and complement input clock phases;
//          out_clk_edge pulses on each rising edge of the output data clock pair
// Notes: data pins are split into dq_in, dq_out and dq_oe_n (low while driving)
// Notes on behaviour
// - write words are captured from the data pins on both input clock phases
// - while a read is active the stored words are driven onto the data pins
// - read words launch on each rising edge of the output clock pair, two per period
// - in single clock mode read words launch on the input clock phases instead
// - with no read word to launch the data drivers float without any command
// - every write, and every read loaded while no read burst is stalled, moves exactly two words as one burst
// - byte write selects are sampled with each write word and a high one keeps the byte
// - the start address low bit seeds the burst counter, which steps linearly
`timescale 1ns/1ps
module ddrsb_port #(
    parameter int DW = ddrsb_pkg::DATA_W,
    parameter int AW = ddrsb_pkg::ADDR_W,
    parameter int NB = ddrsb_pkg::DATA_W / ddrsb_pkg::BYTE_W,
    parameter int FD = ddrsb_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic load_strobe_n,
    input wire logic read_not_write,
    input wire logic [AW-2:0] addr_hi,
    input wire logic burst_start_lsb,
    input wire logic [NB-1:0] byte_write_select_n,
    input wire logic [DW-1:0] dq_in,
    input wire logic single_clk_mode,
    input wire logic out_clk_edge,
    output logic [DW-1:0] dq_out,
    output logic dq_oe_n,
    output logic k_phase
);
    localparam int BW = ddrsb_pkg::BYTE_W;

    logic [DW-1:0] mem [2**AW];
    logic phase_r;
    ddrsb_pkg::ddrsb_wr_state_t wr_state_r;
    logic [AW-1:0] wr_addr_r;
    logic [AW-1:0] wr_word_addr;
    logic [1:0] rd_left_r;
    logic rd_idx_r;
    logic [AW-1:0] rd_addr_r;
    logic [AW-1:0] rd_word_addr;
    logic k_edge;
    logic accept;
    logic launch_en;
    logic rd_push;

    ddrsb_stream_if #(.W(DW)) fill_s ();
    ddrsb_stream_if #(.W(DW)) drain_s ();

    // word address inside a burst: low bit steps linearly and wraps
    function automatic logic [AW-1:0] burst_addr(input logic [AW-1:0] base, input logic idx);
        burst_addr = {base[AW-1:1], base[0] ^ idx};
    endfunction

    // phase divider: one flop toggling per cycle marks the true clock edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_r <= ddrsb_pkg::PHASE_RST;
            k_phase <= ddrsb_pkg::PHASE_RST;
        end else begin
            phase_r <= ~phase_r;
            k_phase <= ~phase_r;
        end
    end

    // a transaction is loaded only on a true clock edge with the strobe low
    assign k_edge = (phase_r == ddrsb_pkg::PHASE_K);
    assign accept = k_edge && !load_strobe_n;

    // write burst: word 0 on the next complement edge, word 1 on the next true edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_state_r <= ddrsb_pkg::DDRSB_WR_IDLE;
            wr_addr_r <= '0;
        end else begin
            if (accept && read_not_write != ddrsb_pkg::DIR_READ) begin
                wr_addr_r <= {addr_hi, burst_start_lsb};
            end
            unique case (wr_state_r)
                ddrsb_pkg::DDRSB_WR_IDLE: begin
                    if (accept && read_not_write != ddrsb_pkg::DIR_READ) begin
                        wr_state_r <= ddrsb_pkg::DDRSB_WR_W0;
                    end
                end
                ddrsb_pkg::DDRSB_WR_W0: begin
                    wr_state_r <= ddrsb_pkg::DDRSB_WR_W1;
                end
                ddrsb_pkg::DDRSB_WR_W1: begin
                    if (accept && read_not_write != ddrsb_pkg::DIR_READ) begin
                        wr_state_r <= ddrsb_pkg::DDRSB_WR_W0;
                    end else begin
                        wr_state_r <= ddrsb_pkg::DDRSB_WR_IDLE;
                    end
                end
                default: begin
                    wr_state_r <= ddrsb_pkg::DDRSB_WR_IDLE;
                end
            endcase
        end
    end

    assign wr_word_addr = burst_addr(wr_addr_r, wr_state_r == ddrsb_pkg::DDRSB_WR_W1);

    // storage write with per-byte selects
    always_ff @(posedge core_clk) begin
        if (wr_state_r != ddrsb_pkg::DDRSB_WR_IDLE) begin
            for (int b = 0; b < NB; b++) begin
                if (!byte_write_select_n[b]) begin
                    mem[wr_word_addr][b*BW +: BW] <= dq_in[b*BW +: BW];
                end
            end
        end
    end

    // read burst: two words pushed into the buffer, stalled while it is full
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_left_r <= ddrsb_pkg::BURST_NONE;
            rd_idx_r <= 1'b0;
            rd_addr_r <= '0;
        end else if (accept && read_not_write == ddrsb_pkg::DIR_READ &&
                     (rd_left_r == ddrsb_pkg::BURST_NONE ||
                      (rd_left_r == 2'h1 && rd_push))) begin
            // back-to-back loads: the running burst hands over its last word this cycle
            rd_left_r <= ddrsb_pkg::BURST_LEN;
            rd_idx_r <= 1'b0;
            rd_addr_r <= {addr_hi, burst_start_lsb};
        end else if (rd_push) begin
            rd_left_r <= rd_left_r - 2'h1;
            rd_idx_r <= ~rd_idx_r;
        end
    end

    assign rd_word_addr = burst_addr(rd_addr_r, rd_idx_r);
    assign rd_push = (rd_left_r != ddrsb_pkg::BURST_NONE) && fill_s.ready;
    assign fill_s.valid = (rd_left_r != ddrsb_pkg::BURST_NONE);
    assign fill_s.data = mem[rd_word_addr];

    ddrsb_fifo #(.W(DW), .DEPTH(FD)) u_rd_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_s(fill_s),
        .out_s(drain_s)
    );

    // launch edges: output clock pair, or every input phase in single clock mode
    assign launch_en = single_clk_mode ? 1'b1 : out_clk_edge;
    assign drain_s.ready = launch_en;

    // pin drivers: drive a launched word, otherwise float
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dq_out <= '0;
            dq_oe_n <= ddrsb_pkg::OE_N_RST;
        end else if (launch_en && drain_s.valid) begin
            dq_out <= drain_s.data;
            dq_oe_n <= 1'b0;
        end else begin
            dq_oe_n <= 1'b1;
        end
    end

    property p_wr_burst;
        @(posedge core_clk) disable iff (rst)
        (accept && !read_not_write) |=>
            (wr_state_r == ddrsb_pkg::DDRSB_WR_W0) ##1 (wr_state_r == ddrsb_pkg::DDRSB_WR_W1);
    endproperty
    a_wr_burst: assert property (p_wr_burst) else $error("write burst is not two words");

    property p_wr_capture;
        @(posedge core_clk) disable iff (rst)
        (wr_state_r != ddrsb_pkg::DDRSB_WR_IDLE && !byte_write_select_n[0]) |=>
            mem[$past(wr_word_addr)][BW-1:0] == $past(dq_in[BW-1:0]);
    endproperty
    a_wr_capture: assert property (p_wr_capture) else $error("write word not captured");

    property p_bws_keep;
        @(posedge core_clk) disable iff (rst)
        (wr_state_r != ddrsb_pkg::DDRSB_WR_IDLE && byte_write_select_n[0]) |=>
            mem[$past(wr_word_addr)][BW-1:0] == $past(mem[wr_word_addr][BW-1:0]);
    endproperty
    a_bws_keep: assert property (p_bws_keep) else $error("deselected byte was written");

    property p_rd_load;
        @(posedge core_clk) disable iff (rst)
        (accept && read_not_write && rd_left_r == ddrsb_pkg::BURST_NONE) |=>
            (rd_left_r == ddrsb_pkg::BURST_LEN && rd_addr_r[0] == $past(burst_start_lsb));
    endproperty
    a_rd_load: assert property (p_rd_load) else $error("read burst not loaded");

    property p_lsb_step;
        @(posedge core_clk) disable iff (rst)
        (rd_push && rd_idx_r) |-> (rd_word_addr[0] != rd_addr_r[0] &&
                                   rd_word_addr[AW-1:1] == rd_addr_r[AW-1:1]);
    endproperty
    a_lsb_step: assert property (p_lsb_step) else $error("burst counter did not step");

    property p_idle_hold;
        @(posedge core_clk) disable iff (rst)
        (load_strobe_n && wr_state_r != ddrsb_pkg::DDRSB_WR_W0) |=>
            (wr_state_r == ddrsb_pkg::DDRSB_WR_IDLE);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("burst began with load high");

    property p_run_on;
        @(posedge core_clk) disable iff (rst)
        (wr_state_r == ddrsb_pkg::DDRSB_WR_W0 && load_strobe_n) |=>
            (wr_state_r == ddrsb_pkg::DDRSB_WR_W1);
    endproperty
    a_run_on: assert property (p_run_on) else $error("running burst cut short");

    property p_single_launch;
        @(posedge core_clk) disable iff (rst)
        (single_clk_mode && drain_s.valid) |=> (!dq_oe_n && dq_out == $past(drain_s.data));
    endproperty
    a_single_launch: assert property (p_single_launch) else $error("no launch");

    property p_dual_wait;
        @(posedge core_clk) disable iff (rst)
        (!single_clk_mode && !out_clk_edge) |=> dq_oe_n;
    endproperty
    a_dual_wait: assert property (p_dual_wait) else $error("launch off clock");

    property p_float;
        @(posedge core_clk) disable iff (rst)
        (!drain_s.valid && !fill_s.valid) [*2] |=> dq_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("pins driven with no read");

    property p_rd_drive;
        @(posedge core_clk) disable iff (rst)
        (accept && read_not_write && rd_left_r == ddrsb_pkg::BURST_NONE && !drain_s.valid)
            ##1 single_clk_mode [*3] |-> ##[0:1] !dq_oe_n;
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
endmodule

// >>> ddrsb_ctl_model.sv
// Purpose: behavioural memory controller driving the load and write side of the port
// Assumes: k_phase low marks a cycle whose closing edge may take a load
// Notes: drives at falling edges; idle lines carry inverted values so stale data never helps
`timescale 1ns/1ps
module ddrsb_ctl_model (
    input wire logic core_clk,
    input wire logic k_phase,
    output logic load_strobe_n,
    output logic read_not_write,
    output logic [ddrsb_pkg::ADDR_W-2:0] addr_hi,
    output logic burst_start_lsb,
    output logic [3:0] byte_write_select_n,
    output logic [ddrsb_pkg::DATA_W-1:0] dq_in
);
    // idle values at time zero
    initial begin
        load_strobe_n = 1'h1;
        read_not_write = 1'h0;
        addr_hi = '0;
        burst_start_lsb = 1'h0;
        byte_write_select_n = 4'hf;
        dq_in = '0;
    end

    // one load on a phase-0 cycle, address and direction presented together
    task automatic load(input logic rnw, input logic [ddrsb_pkg::ADDR_W-2:0] hi, input logic lsb);
        int i;
        i = 0;
        do begin
            @(negedge core_clk);
            i++;
        end while (k_phase !== 1'b0 && i < 8);
        load_strobe_n = 1'h0;
        read_not_write = rnw;
        addr_hi = hi;
        burst_start_lsb = lsb;
        @(negedge core_clk);
        load_strobe_n = 1'h1;
        read_not_write = ~rnw;
        addr_hi = ~hi;
        burst_start_lsb = ~lsb;
    endtask

    // write burst: two words, selects sampled with each word
    task automatic wr(input logic [ddrsb_pkg::ADDR_W-2:0] hi, input logic lsb,
                      input logic [35:0] w0, input logic [35:0] w1,
                      input logic [3:0] b0, input logic [3:0] b1);
        load(1'h0, hi, lsb);
        dq_in = w0;
        byte_write_select_n = b0;
        @(negedge core_clk);
        dq_in = w1;
        byte_write_select_n = b1;
        @(negedge core_clk);
        dq_in = ~w1;
        byte_write_select_n = 4'hf;
    endtask

    // read request
    task automatic rd(input logic [ddrsb_pkg::ADDR_W-2:0] hi, input logic lsb);
        load(1'h1, hi, lsb);
    endtask
endmodule

// >>> ddrsb_port_bench.sv
// Purpose: self-checking bench of the burst-of-two port
// Assumes: controller model drives the load side; bench drives clock mode and output edges
// Notes: words are counted at falling edges while the drivers are on
`timescale 1ns/1ps
module ddrsb_port_bench;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic single_clk_mode = 1'h1;
    logic out_clk_edge = 1'h0;
    logic load_strobe_n, read_not_write, burst_start_lsb, dq_oe_n, k_phase;
    logic [17:0] addr_hi;
    logic [3:0] byte_write_select_n;
    logic [35:0] dq_in, dq_out;
    logic [35:0] q[$];
    int n_errors = 0;
    int tests_run = 0;

    always #5 core_clk = ~core_clk;

    ddrsb_ctl_model ctl (.core_clk(core_clk), .k_phase(k_phase),
        .load_strobe_n(load_strobe_n), .read_not_write(read_not_write), .addr_hi(addr_hi),
        .burst_start_lsb(burst_start_lsb), .byte_write_select_n(byte_write_select_n),
        .dq_in(dq_in));

    ddrsb_port dut (.core_clk(core_clk), .rst(rst), .load_strobe_n(load_strobe_n),
        .read_not_write(read_not_write), .addr_hi(addr_hi), .burst_start_lsb(burst_start_lsb),
        .byte_write_select_n(byte_write_select_n), .dq_in(dq_in),
        .single_clk_mode(single_clk_mode), .out_clk_edge(out_clk_edge), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .k_phase(k_phase));

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // collect launched words over n cycles, pulsing output edges if asked
    task automatic grab(input int n, input int pulses);
        q.delete();
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            if (dq_oe_n === 1'b0) q.push_back(dq_out);
            out_clk_edge = (i < 2 * pulses) && (i % 2 == 0);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // drivers float out of reset and stay off when idle
    task automatic s_reset();
        chk({35'h0, dq_oe_n}, 36'h1);
        chk(dq_out, 36'h0);
        chk({35'h0, k_phase}, 36'h0);
        grab(6, 0);
        chk(36'(q.size()), 36'h0);
    endtask

    // write a burst, read it back in single clock mode
    task automatic s_write_read();
        ctl.wr(18'h5, 1'h0, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
        ctl.rd(18'h5, 1'h0);
        grab(8, 0);
        chk(36'(q.size()), 36'h2);
        chk(q[0], 36'h123456789);
        chk(q[1], 36'hfedcba987);
        grab(4, 0);
        chk(36'(q.size()), 36'h0);
    endtask

    // odd start address: second word goes to the even location
    task automatic s_lsb();
        ctl.wr(18'h6, 1'h1, 36'h0a5a5a5a5, 36'h5a5a5a5a0, 4'h0, 4'h0);
        ctl.rd(18'h6, 1'h0);
        grab(8, 0);
        chk(q[0], 36'h5a5a5a5a0);
        chk(q[1], 36'h0a5a5a5a5);
    endtask

    // high selects keep their bytes, per word
    task automatic s_bytes();
        logic [35:0] k0, k1;
        k0 = 36'h007fc01ff;
        k1 = 36'hff803fe00;
        ctl.wr(18'h5, 1'h0, 36'h111111111, 36'h222222222, 4'h5, 4'ha);
        ctl.rd(18'h5, 1'h0);
        grab(8, 0);
        chk(q[0], (36'h123456789 & k0) | (36'h111111111 & ~k0));
        chk(q[1], (36'hfedcba987 & k1) | (36'h222222222 & ~k1));
    endtask

    // output clock mode: nothing launches without edges, buffer fills then drains in order
    task automatic s_dual();
        single_clk_mode = 1'h0;
        ctl.rd(18'h5, 1'h0);
        ctl.rd(18'h6, 1'h0);
        grab(8, 0);
        chk(36'(q.size()), 36'h0);
        grab(12, 4);
        chk(36'(q.size()), 36'h4);
        chk(q[0], (36'h123456789 & 36'h007fc01ff) | (36'h111111111 & ~36'h007fc01ff));
        chk(q[1], (36'hfedcba987 & 36'hff803fe00) | (36'h222222222 & ~36'hff803fe00));
        chk(q[2], 36'h5a5a5a5a0);
        chk(q[3], 36'h0a5a5a5a5);
        grab(4, 0);
        chk(36'(q.size()), 36'h0);
        single_clk_mode = 1'h1;
    endtask

    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'h0;
        s_reset();
        s_write_read();
        s_lsb();
        s_bytes();
        s_dual();
        conclude();
    end

    // hang guard, far beyond the hundred or so cycles the tests need
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule
